// ===== src/fdcmd_defs.vh
// Purpose: Shared constants of the disk command interpreter
// Assumes: 100 MHz aclk, AXI4-Lite register access
// Notes: Definitions only
`ifndef FDCMD_DEFS_VH
`define FDCMD_DEFS_VH
// Register byte offsets
`define FDCMD_REG_DATA 4'h0
`define FDCMD_REG_STAT 4'h4
`define FDCMD_REG_CFG 4'h8
`define FDCMD_REG_ST3 4'hC
// Configuration fields
`define FDCMD_CFG_POLL_DIS 0
`define FDCMD_CFG_WRITE_GATE_OPTION 1
`define FDCMD_CFG_VERIFY 2
`define FDCMD_CFG_NON_DMA 3
`define FDCMD_CFG_SRT_LO 4
`define FDCMD_CFG_PRE_LO 8
`define FDCMD_CFG_SPT_LO 16
`define FDCMD_CFG_RESET 32'h00000000
// Opcode low field values and flag positions
`define FDCMD_OP_READ 5'h06
`define FDCMD_OP_READ_DEL 5'h0C
`define FDCMD_OP_SENSE_INT 5'h08
`define FDCMD_OP_REL_SEEK 5'h0F
`define FDCMD_OP_MT 7
`define FDCMD_OP_MFM 6
`define FDCMD_OP_SK 5
// Command lengths in bytes
`define FDCMD_LEN_READ 4'h9
`define FDCMD_LEN_SEEK 4'h3
// Status byte fields
`define FDCMD_ST0_INVALID 8'h80
`define FDCMD_ST0_SEEK_END 8'h20
`define FDCMD_ST2_CTRL_MARK 8'h40
// Timing
`define FDCMD_CLK_PERIOD_NS 10
`define FDCMD_STEP_UNIT_NS 500000
`define FDCMD_POLL_NS 1000000
`define FDCMD_BASE_SECTOR_LEN 16'h0080
`define FDCMD_AXI_OKAY 2'b00
`define FDCMD_AXI_SLVERR 2'b10
`endif

// ===== src/fdcmd_step.v
// Purpose: Step pulse sequencer spaced by the programmed interval
// Assumes: Interval of (16 - rate) units, rate field 0 gives 8 ms
// Notes: One pulse per cycle-wide strobe, first pulse after one interval
`timescale 1ns/1ps
`default_nettype none
module fdcmd_step #(
  parameter UNIT_CYC = 50000
) (
  // Clock and control
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // Request
  input wire start,
  input wire [7:0] steps,
  input wire [3:0] rate,
  // Status
  output reg step_ff,
  output reg busy_ff
);
  reg [7:0] left_ff;
  reg [23:0] tmr_ff;
  wire [23:0] interval;

  // Rate F is the shortest spacing, 0 the longest
  assign interval = (24'h000010 - {20'h00000, rate}) * UNIT_CYC[23:0];

  // Counts down the interval, then issues one step
  always @(posedge aclk) begin
    if (!aresetn) begin
      left_ff <= 8'h00;
      tmr_ff <= 24'h000000;
      step_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      step_ff <= 1'b0;
      if (start && !busy_ff) begin
        left_ff <= steps;
        tmr_ff <= interval;
        busy_ff <= (steps != 8'h00);
      end else if (busy_ff) begin
        if (tmr_ff > 24'h000001) begin
          tmr_ff <= tmr_ff - 24'h000001;
        end else begin
          step_ff <= 1'b1;
          tmr_ff <= interval;
          left_ff <= left_ff - 8'h01;
          busy_ff <= (left_ff != 8'h01);
        end
      end
    end
  end
endmodule // fdcmd_step
`default_nettype wire

// ===== src/fdcmd_top.v
// Purpose: Command, execution and result sequencer of a disk controller
// Assumes: AXI4-Lite host access, byte stream from the drive side
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fdcmd_defs.vh"
module fdcmd_top #(
  parameter STEP_UNIT_CYC = `FDCMD_STEP_UNIT_NS / `FDCMD_CLK_PERIOD_NS,
  parameter POLL_CYC = `FDCMD_POLL_NS / `FDCMD_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // AXI4-Lite write
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Drive data stream
  input wire [7:0] drive_data,
  input wire drive_deleted,
  input wire drive_valid,
  output wire drive_ready,
  output reg [7:0] drive_cyl_ff,
  output reg drive_head_ff,
  output reg [7:0] drive_sector_ff,
  output reg [1:0] drive_unit_ff,
  output reg mfm_mode_ff,
  // Drive control
  output wire step_pulse,
  output reg step_dir_ff,
  output wire poll_pulse,
  output wire precomp_active,
  output wire write_gate_early,
  output wire dma_req,
  output wire byte_req
);
  localparam S_CMD = 4'b0001;
  localparam S_EXEC = 4'b0010;
  localparam S_SEEK = 4'b0100;
  localparam S_RES = 4'b1000;

  reg [3:0] state_ff;
  reg [31:0] cfg_ff;
  reg [7:0] cmd_mem [0:8];
  reg [7:0] res_mem [0:6];
  reg [3:0] cmd_cnt_ff, res_idx_ff, res_len_ff;
  reg [7:0] present_cylinder_ff, byte_ff, status_byte_two_ff, done_sec_ff;
  reg byte_pend_ff, seek_end_ff, deleted_ff, first_ff, stop_ff, poll_ff;
  reg [15:0] byte_cnt_ff;
  reg [19:0] poll_cnt_ff;
  reg [3:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg aw_ff, w_ff;
  reg wstrb_lo_ff;
  integer i;
  integer j;

  wire poll_disable = cfg_ff[`FDCMD_CFG_POLL_DIS];
  wire write_gate_option = cfg_ff[`FDCMD_CFG_WRITE_GATE_OPTION];
  wire verify_enable = cfg_ff[`FDCMD_CFG_VERIFY];
  wire non_dma_flag = cfg_ff[`FDCMD_CFG_NON_DMA];
  wire [3:0] step_rate_interval = cfg_ff[`FDCMD_CFG_SRT_LO+3:`FDCMD_CFG_SRT_LO];
  wire [7:0] precomp_start_track = cfg_ff[`FDCMD_CFG_PRE_LO+7:`FDCMD_CFG_PRE_LO];
  wire [7:0] sectors_per_track = cfg_ff[`FDCMD_CFG_SPT_LO+7:`FDCMD_CFG_SPT_LO];
  wire [4:0] op_code = cmd_mem[0][4:0];
  wire multi_track_flag = cmd_mem[0][`FDCMD_OP_MT];
  wire skip_flag = cmd_mem[0][`FDCMD_OP_SK];
  wire is_del = (op_code == `FDCMD_OP_READ_DEL);
  wire [7:0] size_code = cmd_mem[5];
  wire [7:0] end_sector = cmd_mem[6];
  wire [7:0] data_length = cmd_mem[8];
  wire step_busy;
  wire [7:0] status_byte_zero;
  wire [7:0] status_byte_three;

  // Sector length; code zero takes the data length byte
  wire [15:0] sec_len = (size_code == 8'h00) ? {8'h00, data_length} :
    (`FDCMD_BASE_SECTOR_LEN << size_code[2:0]);
  // Skip when the mark type disagrees with the command and skip is set
  wire mark_bad = is_del ? !deleted_ff : deleted_ff;
  wire skipping = skip_flag && mark_bad;
  wire last_byte = (byte_cnt_ff == sec_len - 16'h0001);
  // Verify counts sectors per track, read runs to the end sector
  wire run_end = verify_enable ? (done_sec_ff == sectors_per_track - 8'h01)
    : (drive_sector_ff == end_sector);
  wire take = drive_valid && drive_ready;

  // AXI handshakes: one write and one read at a time
  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wr_go = aw_ff && w_ff;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire data_wr = wr_go && (awaddr_ff == `FDCMD_REG_DATA) && wstrb_lo_ff;
  wire data_rd = rd_go && (s_axi_araddr == `FDCMD_REG_DATA);

  // Drive side stalls while the host has not taken the held byte
  assign drive_ready = state_ff[1] && !byte_pend_ff && !stop_ff;
  assign dma_req = byte_pend_ff && !non_dma_flag;
  assign byte_req = byte_pend_ff && non_dma_flag;
  assign precomp_active = (drive_cyl_ff >= precomp_start_track);
  assign write_gate_early = write_gate_option;
  assign poll_pulse = poll_ff;
  assign status_byte_zero = {2'b00, seek_end_ff, 2'b00, drive_head_ff, drive_unit_ff};
  assign status_byte_three = {3'b000, present_cylinder_ff == 8'h00, 1'b0,
    drive_head_ff, drive_unit_ff};

  // Step sequencer for relative seeks
  fdcmd_step #(
    .UNIT_CYC(STEP_UNIT_CYC)
  ) u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(state_ff[2] && !step_busy && !seek_end_ff),
    .steps(cmd_mem[2]),
    .rate(step_rate_interval),
    .step_ff(step_pulse),
    .busy_ff(step_busy)
  );

  // Drive polling runs only while enabled and idle
  always @(posedge aclk) begin
    if (!aresetn) begin
      poll_cnt_ff <= 20'h00000;
      poll_ff <= 1'b0;
    end else if (ce) begin
      poll_ff <= 1'b0;
      if (poll_disable || !state_ff[0]) begin
        poll_cnt_ff <= 20'h00000;
      end else if (poll_cnt_ff >= POLL_CYC[19:0] - 20'h00001) begin
        poll_cnt_ff <= 20'h00000;
        poll_ff <= 1'b1;
      end else begin
        poll_cnt_ff <= poll_cnt_ff + 20'h00001;
      end
    end
  end

  // AXI write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h00000000;
      wstrb_lo_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FDCMD_AXI_OKAY;
      cfg_ff <= `FDCMD_CFG_RESET;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_lo_ff <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff == `FDCMD_REG_DATA || awaddr_ff == `FDCMD_REG_CFG) ?
          `FDCMD_AXI_OKAY : `FDCMD_AXI_SLVERR;
        if (awaddr_ff == `FDCMD_REG_CFG) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (wstrb_lo_all(i)) begin
              cfg_ff[i*8 +: 8] <= wdata_ff[i*8 +: 8];
            end
          end
        end
      end
    end
  end

  // Byte lanes of the configuration write
  reg [3:0] wstrb_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      wstrb_ff <= 4'h0;
    end else if (ce && s_axi_wvalid && s_axi_wready) begin
      wstrb_ff <= s_axi_wstrb;
    end
  end
  function wstrb_lo_all;
    input integer lane;
    begin
      wstrb_lo_all = wstrb_ff[lane];
    end
  endfunction

  // AXI read mux; reading the data port pops the current byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FDCMD_AXI_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `FDCMD_AXI_OKAY;
        case (s_axi_araddr)
          `FDCMD_REG_DATA: s_axi_rdata <= {24'h000000,
            state_ff[3] ? res_mem[res_idx_ff[2:0]] : (byte_pend_ff ? byte_ff : 8'h00)};
          `FDCMD_REG_STAT: s_axi_rdata <= {16'h0000, present_cylinder_ff, 3'b000,
            step_busy, byte_pend_ff, state_ff[3], state_ff[1] | state_ff[2], state_ff[0]};
          `FDCMD_REG_CFG: s_axi_rdata <= cfg_ff;
          `FDCMD_REG_ST3: s_axi_rdata <= {24'h000000, status_byte_three};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FDCMD_AXI_SLVERR;
          end
        endcase
      end
    end
  end

  // Phase sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_CMD;
      cmd_cnt_ff <= 4'h0;
      res_idx_ff <= 4'h0;
      res_len_ff <= 4'h0;
      present_cylinder_ff <= 8'h00;
      byte_ff <= 8'h00;
      byte_pend_ff <= 1'b0;
      seek_end_ff <= 1'b0;
      deleted_ff <= 1'b0;
      first_ff <= 1'b1;
      stop_ff <= 1'b0;
      byte_cnt_ff <= 16'h0000;
      done_sec_ff <= 8'h00;
      status_byte_two_ff <= 8'h00;
      drive_cyl_ff <= 8'h00;
      drive_head_ff <= 1'b0;
      drive_sector_ff <= 8'h00;
      drive_unit_ff <= 2'b00;
      mfm_mode_ff <= 1'b0;
      step_dir_ff <= 1'b0;
      for (j = 0; j < 9; j = j + 1) begin
        cmd_mem[j] <= 8'h00;
      end
      for (j = 0; j < 7; j = j + 1) begin
        res_mem[j] <= 8'h00;
      end
    end else if (ce) begin
      case (state_ff)
        S_CMD: begin
          if (data_wr) begin
            cmd_mem[cmd_cnt_ff] <= wdata_ff[7:0];
            cmd_cnt_ff <= cmd_cnt_ff + 4'h1;
            if (cmd_cnt_ff == 4'h0 && wdata_ff[4:0] == `FDCMD_OP_SENSE_INT) begin
              res_mem[0] <= status_byte_zero;
              res_mem[1] <= present_cylinder_ff;
              seek_end_ff <= 1'b0;
              res_len_ff <= 4'h2;
              res_idx_ff <= 4'h0;
              cmd_cnt_ff <= 4'h0;
              state_ff <= S_RES;
            end else if (cmd_cnt_ff == 4'h0 && wdata_ff[4:0] != `FDCMD_OP_READ &&
              wdata_ff[4:0] != `FDCMD_OP_READ_DEL && wdata_ff[4:0] != `FDCMD_OP_REL_SEEK) begin
              res_mem[0] <= `FDCMD_ST0_INVALID;
              res_len_ff <= 4'h1;
              res_idx_ff <= 4'h0;
              cmd_cnt_ff <= 4'h0;
              state_ff <= S_RES;
            end else if (cmd_cnt_ff != 4'h0 && op_code == `FDCMD_OP_REL_SEEK &&
              cmd_cnt_ff == `FDCMD_LEN_SEEK - 4'h1) begin
              cmd_cnt_ff <= 4'h0;
              step_dir_ff <= cmd_mem[0][`FDCMD_OP_MFM];
              drive_unit_ff <= cmd_mem[1][1:0];
              seek_end_ff <= 1'b0;
              state_ff <= S_SEEK;
            end else if (cmd_cnt_ff == `FDCMD_LEN_READ - 4'h1) begin
              cmd_cnt_ff <= 4'h0;
              mfm_mode_ff <= cmd_mem[0][`FDCMD_OP_MFM];
              drive_unit_ff <= cmd_mem[1][1:0];
              drive_head_ff <= cmd_mem[1][2];
              drive_cyl_ff <= cmd_mem[2];
              drive_sector_ff <= cmd_mem[4];
              byte_cnt_ff <= 16'h0000;
              done_sec_ff <= 8'h00;
              first_ff <= 1'b1;
              stop_ff <= 1'b0;
              status_byte_two_ff <= 8'h00;
              state_ff <= S_EXEC;
            end
          end
        end
        S_SEEK: begin
          // Present cylinder moves one per step pulse
          if (step_pulse) begin
            present_cylinder_ff <= step_dir_ff ? present_cylinder_ff - 8'h01 :
              present_cylinder_ff + 8'h01;
          end
          if (!step_busy && !step_pulse && (seek_end_ff || cmd_mem[2] == 8'h00)) begin
            seek_end_ff <= 1'b1;
            state_ff <= S_CMD;
          end else if (step_busy) begin
            seek_end_ff <= 1'b1;
          end
        end
        S_EXEC: begin
          if (data_rd && byte_pend_ff) begin
            byte_pend_ff <= 1'b0;
          end
          if (take) begin
            if (first_ff) begin
              deleted_ff <= drive_deleted;
            end
            first_ff <= last_byte;
            byte_cnt_ff <= last_byte ? 16'h0000 : byte_cnt_ff + 16'h0001;
            // Bytes of a skipped sector, and all bytes while verify is set, are dropped; others held for the host
            if (!(skip_flag && (first_ff ? (is_del ? !drive_deleted : drive_deleted)
              : mark_bad)) && !verify_enable) begin
              byte_ff <= drive_data;
              byte_pend_ff <= 1'b1;
            end
            if (last_byte) begin
              done_sec_ff <= done_sec_ff + 8'h01;
              if (!skip_flag && (first_ff ? (is_del ? !drive_deleted : drive_deleted)
                : mark_bad)) begin
                status_byte_two_ff <= `FDCMD_ST2_CTRL_MARK;
                stop_ff <= 1'b1;
              end else if (run_end && multi_track_flag && !drive_head_ff) begin
                drive_head_ff <= 1'b1;
                drive_sector_ff <= 8'h01;
              end else if (run_end) begin
                stop_ff <= 1'b1;
                drive_sector_ff <= 8'h01;
                drive_cyl_ff <= drive_cyl_ff + 8'h01;
              end else begin
                drive_sector_ff <= drive_sector_ff + 8'h01;
              end
            end
          end
          if (stop_ff && !byte_pend_ff) begin
            res_mem[0] <= status_byte_zero;
            res_mem[1] <= 8'h00;
            res_mem[2] <= status_byte_two_ff;
            res_mem[3] <= drive_cyl_ff;
            res_mem[4] <= {7'h00, drive_head_ff};
            res_mem[5] <= drive_sector_ff;
            res_mem[6] <= size_code;
            res_len_ff <= 4'h7;
            res_idx_ff <= 4'h0;
            state_ff <= S_RES;
          end
        end
        S_RES: begin
          // Each data-port read advances; the last one reopens commands
          if (data_rd) begin
            res_idx_ff <= res_idx_ff + 4'h1;
            if (res_idx_ff == res_len_ff - 4'h1) begin
              state_ff <= S_CMD;
            end
          end
        end
        default: state_ff <= S_CMD;
      endcase
    end
  end
endmodule // fdcmd_top
`default_nettype wire

// ===== verification/fdcmd_drv_model.sv
// Purpose: Drive-side byte stream model for the command interpreter
// Assumes: Byte is {head, sector[2:0], index}, deleted mark per sector
// Notes: Offers a byte only while the controller is reading
`timescale 1ns/1ps
`default_nettype none
module fdcmd_drv_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  input wire logic rewind,
  input wire logic drive_ready,
  input wire logic drive_head_ff,
  input wire logic [7:0] drive_sector_ff,
  input wire logic [7:0] del_mask,
  // Stream out
  output logic [7:0] drive_data,
  output logic drive_deleted,
  output logic drive_valid
);
  logic [3:0] idx_ff;
  logic [8:0] id_ff;
  // Byte index restarts when the sector under the head changes
  always @(posedge aclk) begin
    if (!aresetn) begin
      drive_valid <= 1'b0;
      drive_data <= 8'h00;
      drive_deleted <= 1'b0;
      idx_ff <= 4'h0;
      id_ff <= 9'h1FF;
    end else if (rewind) begin
      id_ff <= 9'h1FF;
    end else if (drive_valid && drive_ready) begin
      drive_valid <= 1'b0;
      drive_data <= ~drive_data; // Released line shows the inverted byte, then toggles each idle cycle
      idx_ff <= idx_ff + 4'h1;
    end else if (!drive_valid && drive_ready) begin
      drive_valid <= 1'b1;
      drive_deleted <= del_mask[drive_sector_ff[2:0]];
      id_ff <= {drive_head_ff, drive_sector_ff};
      if ({drive_head_ff, drive_sector_ff} != id_ff) begin
        idx_ff <= 4'h0;
        drive_data <= {drive_head_ff, drive_sector_ff[2:0], 4'h0};
      end else begin
        drive_data <= {drive_head_ff, drive_sector_ff[2:0], idx_ff};
      end
    end else if (!drive_valid) begin
      drive_data <= ~drive_data;
    end
  end
endmodule // fdcmd_drv_model
`default_nettype wire

// ===== verification/fdcmd_top_chk.sv
// Purpose: Port checker for the disk command interpreter
// Assumes: Config is written as whole words at offset 8
// Notes: Shadows config from bus writes, settles for three cycles
`timescale 1ns/1ps
`default_nettype none
module fdcmd_top_chk #(
  parameter STEP_UNIT_CYC = 4,
  parameter POLL_CYC = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Host bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Drive side
  input wire logic drive_ready,
  input wire logic [7:0] drive_cyl_ff,
  input wire logic step_pulse,
  input wire logic poll_pulse,
  input wire logic precomp_active,
  input wire logic write_gate_early,
  input wire logic dma_req,
  input wire logic byte_req
);
  logic [31:0] cfg_ff;
  int age_ff;
  int gap_ff;
  int ival;
  assign ival = (16 - cfg_ff[7:4]) * STEP_UNIT_CYC;
  // Config shadow; age keeps level checks off while a write lands
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= 32'h0;
      age_ff <= 0;
      gap_ff <= 0;
    end else begin
      gap_ff <= step_pulse ? 0 : gap_ff + 1;
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
          && s_axi_awaddr == 4'h8) begin
        cfg_ff <= s_axi_wdata;
        age_ff <= 0;
      end else if (age_ff < 3) begin
        age_ff <= age_ff + 1;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_resp_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  read_resp_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  step_gap_a: assert property (step_pulse && gap_ff < 2 * ival |-> gap_ff == ival - 1)
    else $error("step spacing wrong");
  poll_off_a: assert property (poll_pulse |-> !(cfg_ff[0] && age_ff >= 3))
    else $error("poll while disabled");
  write_gate_option_lvl_a: assert property (age_ff >= 3 |-> write_gate_early == cfg_ff[1])
    else $error("write gate level wrong");
  precomp_lvl_a: assert property (age_ff >= 3 |-> precomp_active == (drive_cyl_ff >= cfg_ff[15:8]))
    else $error("precomp level wrong");
  req_mode_a: assert property ((dma_req || byte_req) && age_ff >= 3 |-> byte_req == cfg_ff[3] && dma_req == !cfg_ff[3])
    else $error("transfer request mode wrong");
  held_block_a: assert property (dma_req || byte_req |-> !drive_ready)
    else $error("drive taken while byte held");
endmodule // fdcmd_top_chk
bind fdcmd_top fdcmd_top_chk #(.STEP_UNIT_CYC(STEP_UNIT_CYC), .POLL_CYC(POLL_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .drive_ready(drive_ready), .drive_cyl_ff(drive_cyl_ff),
  .step_pulse(step_pulse), .poll_pulse(poll_pulse), .precomp_active(precomp_active),
  .write_gate_early(write_gate_early), .dma_req(dma_req), .byte_req(byte_req));
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Bus-level tests of command, execution and result phases
// Assumes: Step unit of 4 cycles, poll period of 16 cycles
// Notes: Sector 3 carries a deleted mark on both heads
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Host bus
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rewind;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [7:0] del_mask;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp, unit;
  wire [31:0] rdata;
  // Drive side
  wire [7:0] d_data, cyl, sec;
  wire d_del, d_valid, d_ready, head, mfm, stp, dir, poll, pre, wge, dreq, breq;
  int err_total, num_checks, n_step, n_poll;
  logic [31:0] x;
  fdcmd_top #(.STEP_UNIT_CYC(4), .POLL_CYC(16)) dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_data(d_data), .drive_deleted(d_del),
    .drive_valid(d_valid), .drive_ready(d_ready), .drive_cyl_ff(cyl), .drive_head_ff(head),
    .drive_sector_ff(sec), .drive_unit_ff(unit), .mfm_mode_ff(mfm), .step_pulse(stp),
    .step_dir_ff(dir), .poll_pulse(poll), .precomp_active(pre), .write_gate_early(wge),
    .dma_req(dreq), .byte_req(breq));
  fdcmd_drv_model drv (.aclk(aclk), .aresetn(aresetn), .rewind(rewind), .drive_ready(d_ready),
    .drive_head_ff(head), .drive_sector_ff(sec), .del_mask(del_mask), .drive_data(d_data),
    .drive_deleted(d_del), .drive_valid(d_valid));
  // Clock; pulse counters for steps and polls
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (stp === 1'b1) n_step++;
    if (poll === 1'b1) n_poll++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task chkr(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: response %b, expected %b", $time, got, exp);
    end
  endtask
  // Both address and data offered together, each dropped once taken
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (n >= 100) err_total++;
    chkr(bresp, er);
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    d = rdata;
    if (n >= 100) err_total++;
  endtask
  task rdq(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // Nine command bytes of a read; C=5, N=0, data length 4
  task run(input logic [7:0] op, input logic [7:0] hd, input logic [7:0] r, input logic [7:0] eot);
    logic [7:0] b[9];
    rewind <= 1'b1;
    @(posedge aclk);
    rewind <= 1'b0;
    b = '{op, hd, 8'h05, {7'h0, hd[2]}, r, 8'h00, eot, 8'h1B, 8'h04};
    foreach (b[i]) wr(4'h0, {24'h0, b[i]}, 2'b00);
  endtask
  // Sectors s0..s1 of one head, skipping one sector number
  task xfer(input logic h, input int s0, input int s1, input int skp);
    int n;
    for (int s = s0; s <= s1; s++) begin
      for (int i = 0; i < 4 && s != skp; i++) begin
        n = 0;
        while ((dreq | breq) !== 1'b1 && n < 300) begin
          @(posedge aclk);
          n++;
        end
        rdq(4'h0, {24'h0, h, s[2:0], i[3:0]});
      end
    end
  endtask
  task tail(input logic [7:0] st2, input bit full);
    // Skipped last sector delays the result phase; wait for it
    x = 32'h0;
    for (int n = 0; n < 100 && x[2] !== 1'b1; n++) rd(4'h4, x);
    rd(4'h0, x);
    rdq(4'h0, 32'h0);
    rdq(4'h0, {24'h0, st2});
    for (int k = 0; k < 4; k++) begin
      rd(4'h0, x);
      if (full) chk(x, (k == 0) ? 32'h6 : (k == 2) ? 32'h1 : 32'h0);
    end
  endtask
  task wrap_up;
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rewind} = 7'h0;
    {awaddr, araddr, wdata} = 40'h0;
    del_mask = 8'h08;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdq(4'h4, 32'h1);
    rdq(4'h8, 32'h0);
    wr(4'hC, 32'h0, 2'b10);
    wr(4'h4, 32'h0, 2'b10);
    repeat (34) @(posedge aclk);
    chk(n_poll != 0, 1);
    wr(4'h8, 32'h000003E3, 2'b00);
    rdq(4'h8, 32'h000003E3);
    wr(4'h0, 32'h0F, 2'b00);
    wr(4'h0, 32'h00, 2'b00);
    wr(4'h0, 32'h03, 2'b00);
    for (int n = 0; n < 100 && x[0] !== 1'b1; n++) rd(4'h4, x);
    chk(n_step, 3);
    wr(4'h0, 32'h08, 2'b00);
    rd(4'h0, x);
    chk(x & 32'h20, 32'h20);
    rdq(4'h0, 32'h3);
    run(8'h46, 8'h01, 8'h01, 8'h02);
    xfer(1'b0, 1, 2, 0);
    chk({mfm, unit}, 3'b101);
    tail(8'h00, 1'b1);
    rdq(4'h4, 32'h0301);
    wr(4'h8, 32'h000003EB, 2'b00);
    run(8'h26, 8'h00, 8'h02, 8'h04);
    xfer(1'b0, 2, 4, 3);
    tail(8'h00, 1'b0);
    run(8'h06, 8'h00, 8'h03, 8'h04);
    xfer(1'b0, 3, 3, 0);
    tail(8'h40, 1'b0);
    run(8'h2C, 8'h00, 8'h01, 8'h04);
    xfer(1'b0, 3, 3, 0);
    tail(8'h00, 1'b0);
    run(8'hA6, 8'h00, 8'h04, 8'h04);
    xfer(1'b0, 4, 4, 0);
    xfer(1'b1, 1, 4, 3);
    tail(8'h00, 1'b0);
    wr(4'h8, 32'h000203EF, 2'b00);
    run(8'h06, 8'h00, 8'h01, 8'h09);
    tail(8'h00, 1'b1);
    wr(4'h0, 32'h1F, 2'b00);
    rdq(4'h0, 32'h80);
    rdq(4'h4, 32'h0301);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
